// [hdl/sbps_pkg.sv]
package sbps_pkg;

   // ==========
   // register map, byte addresses on the Avalon slave
   localparam logic [7:0] REG_STATUS = 8'h00;
   localparam logic [7:0] REG_BIT_PERIOD = 8'h04;
   localparam logic [7:0] REG_RX_DATA = 8'h08;
   localparam logic [7:0] REG_TX_DATA = 8'h0C;
   localparam logic [7:0] REG_CONTROL = 8'h10;

   // status fields
   localparam int ST_TARGET_LSB = 0;
   localparam int ST_ACTIVE = 2;
   localparam int ST_LOCKED = 3;
   localparam int ST_PORT = 4;
   localparam int ST_RX_VALID = 8;
   localparam int ST_PARITY_ERR = 9;
   localparam int ST_FRAME_ERR = 10;
   localparam int ST_TX_BUSY = 11;

   // control fields
   localparam int CTRL_GO_BIT = 0;

   // ==========
   // memory map seen by the boot decision
   localparam logic [31:0] SRAM_BASE = 32'h2000_0000;
   localparam logic [31:0] LOADER_RAM_BYTES = 32'h0000_0800;
   localparam logic [31:0] FLASH_BANK_ONE_BASE = 32'h0800_0000;
   localparam logic [31:0] FLASH_BANK_TWO_BASE = 32'h0808_0000;
   localparam logic [31:0] SRAM_BYTES_DEFAULT = 32'h0001_0000;

   // ==========
   // serial frame and timing
   localparam logic [7:0] SYNC_BYTE = 8'h7F;
   localparam logic [3:0] RX_SAMPLES = 4'hA;
   localparam logic [3:0] TX_FRAME_BITS = 4'hB;
   localparam int SYNC_HIGH_MIN_BITS = 6;
   localparam int SYNC_HIGH_MAX_BITS = 8;
   localparam int CLK_HZ = 200_000_000;
   localparam int SYS_CLK_DUAL_BANK_HZ = 24_000_000;
   localparam int SYS_CLK_LOW_POWER_HZ = 16_000_000;
   localparam int WDG_REFRESH_US = 1000;
   localparam int WDG_REFRESH_CYCLES = (CLK_HZ / 1_000_000) * WDG_REFRESH_US;

   // ==========
   // types
   typedef enum logic [1:0] {
      TGT_FLASH_ONE = 2'b00,
      TGT_FLASH_TWO = 2'b01,
      TGT_SRAM = 2'b10,
      TGT_LOADER = 2'b11
   } sbps_target_t;

   typedef enum logic [2:0] {
      DET_POLL = 3'b000,
      DET_LOW1 = 3'b001,
      DET_HIGH = 3'b010,
      DET_LOW2 = 3'b011,
      DET_RUN = 3'b100,
      DET_DONE = 3'b101
   } sbps_det_t;

   typedef enum logic [1:0] {
      RX_IDLE = 2'b00,
      RX_START = 2'b01,
      RX_BITS = 2'b10
   } sbps_rx_t;

endpackage : sbps_pkg

// [hdl/sbps_top.sv]
`timescale 1ns/1ps

// Function
// RQ1 - host holds select a high, b low
// RQ2 - poll both ports forever until activity
// RQ3 - sync byte 0x7F triggers baud measure, lock
// RQ4 - selected port locks, other port disabled
// RQ5 - bit rate measured with system tick timer
// RQ6 - frames: eight data, even parity, stop
// RQ7 - single internal oscillator clock, no crystal
// RQ8 - host keeps unused receive line defined
// RQ9 - watchdog prescaler max, periodic refresh
// RQ10 - go command restores touched peripherals first (here peripheral_restore pulses in the same cycle as app_jump)
// RQ11 - flag clear, valid bank: always jump (here pins come first: select a high gives loader or SRAM)
// RQ12 - host sets flag or erases bank words
// RQ13 - flag clear, banks erased, flash pins: loader
// RQ14 - only receive and transmit lines used
// RQ15 - first 2 Kbytes of RAM reserved
// RQ16 - host may drive pins through modem lines
// RQ17 - bank two first, then bank one
// RQ18 - bank valid when word points into SRAM
// RQ19 - time sync low pulses for bit period
// RQ20 - locked port ignores other until reset
module sbps_top #(
   parameter int unsigned PERIOD_W = 16,
   parameter int unsigned WDG_REFRESH_CYCLES = sbps_pkg::WDG_REFRESH_CYCLES,
   parameter logic [31:0] SRAM_BYTES = sbps_pkg::SRAM_BYTES_DEFAULT
)(
   input wire logic clk, // RQ7
   input wire logic reset,
   input wire logic [7:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic boot_select_a,
   input wire logic boot_select_b,
   input wire logic bank_two_boot_flag,
   input wire logic [31:0] bank_one_start_word,
   input wire logic [31:0] bank_two_start_word,
   input wire logic port_one_receive,
   input wire logic port_two_receive,
   output logic port_one_transmit,
   output logic port_two_transmit,
   output logic [1:0] boot_target,
   output logic loader_active,
   output logic loader_ram_reserved,
   output logic app_jump,
   output logic peripheral_restore,
   output logic watchdog_prescaler_max,
   output logic watchdog_refresh
);

   // ==========
   // declarations
   localparam int unsigned WW = PERIOD_W + 3;

   logic sel_a_q, sel_b_q, flag_q, decided_q;
   logic [31:0] word_one_q, word_two_q;
   sbps_pkg::sbps_target_t target_q, target_d;
   logic active_q, ram_res_q, jump_q, restore_q;
   logic wdg_max_q, wdg_ref_q;
   logic [31:0] wdg_cnt_q;
   logic wait_q;
   logic [31:0] rdata_q;
   logic [PERIOD_W-1:0] tick_q, stamp_q, low1_q, period_q, elapsed;
   sbps_pkg::sbps_det_t det_q;
   logic sel_port_q, prev_one_q, prev_two_q;
   logic line, prev_line, fall, rise, fall_one, fall_two;
   logic [WW-1:0] high_min, high_max, low_sum;
   sbps_pkg::sbps_rx_t rx_q;
   logic [PERIOD_W-1:0] rx_cnt_q, tx_cnt_q;
   logic [3:0] rx_n_q, tx_n_q;
   logic [9:0] rx_sh_q, rx_next;
   logic rx_done_q, rx_perr_q, rx_ferr_q;
   logic rx_valid_q, perr_q, ferr_q;
   logic [7:0] rx_data_q;
   logic [10:0] tx_sh_q;
   logic tx_busy_q, tx1_q, tx2_q;
   logic v_one, v_two, locked;
   logic acc, wr_go, wr_tx, rd_rx;

   // ==========
   // boot decision
   // stack word must land inside internal SRAM, top address included
   assign v_one = (word_one_q >= sbps_pkg::SRAM_BASE)
                  && (word_one_q <= sbps_pkg::SRAM_BASE + SRAM_BYTES); // RQ18
   assign v_two = (word_two_q >= sbps_pkg::SRAM_BASE)
                  && (word_two_q <= sbps_pkg::SRAM_BASE + SRAM_BYTES); // RQ18

   // selection table: pins first, then the dual bank walk
   always_comb
   begin
      if (sel_a_q && sel_b_q)
         target_d = sbps_pkg::TGT_SRAM;
      else if (sel_a_q)
         target_d = sbps_pkg::TGT_LOADER; // RQ1
      else if (flag_q)
         target_d = sbps_pkg::TGT_FLASH_ONE;
      else if (v_two)
         target_d = sbps_pkg::TGT_FLASH_TWO; // RQ17
      else if (v_one)
         target_d = sbps_pkg::TGT_FLASH_ONE; // RQ11
      else
         target_d = sbps_pkg::TGT_LOADER; // RQ13
   end

   // straps are followed while reset is held, so the level at release counts
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         sel_a_q <= boot_select_a; // RQ1
         sel_b_q <= boot_select_b;
         flag_q <= bank_two_boot_flag;
         word_one_q <= bank_one_start_word;
         word_two_q <= bank_two_start_word;
         decided_q <= 1'b0;
         target_q <= sbps_pkg::TGT_LOADER;
      end
      else if (!decided_q)
      begin
         decided_q <= 1'b1;
         target_q <= target_d;
      end
   end

   // loader session state, ended only by the go command
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         active_q <= 1'b0;
         ram_res_q <= 1'b0;
         jump_q <= 1'b0;
         restore_q <= 1'b0;
      end
      else
      begin
         jump_q <= 1'b0;
         restore_q <= 1'b0;
         if (!decided_q)
         begin
            active_q <= (target_d == sbps_pkg::TGT_LOADER);
            ram_res_q <= (target_d == sbps_pkg::TGT_LOADER); // RQ15
            jump_q <= (target_d == sbps_pkg::TGT_FLASH_ONE) || (target_d == sbps_pkg::TGT_FLASH_TWO); // RQ11
         end
         else if (wr_go && active_q)
         begin
            restore_q <= 1'b1; // RQ10
            jump_q <= 1'b1;
            active_q <= 1'b0;
            ram_res_q <= 1'b0;
         end
      end
   end

   // ==========
   // watchdog keeper
   // refresh comes well inside the slowest watchdog timeout
   always_ff @(posedge clk)
   begin
      if (reset || !active_q)
      begin
         wdg_max_q <= 1'b0;
         wdg_ref_q <= 1'b0;
         wdg_cnt_q <= 32'h0000_0000;
      end
      else
      begin
         wdg_max_q <= 1'b1; // RQ9
         wdg_ref_q <= (wdg_cnt_q == 32'(WDG_REFRESH_CYCLES - 1));
         if (wdg_cnt_q == 32'(WDG_REFRESH_CYCLES - 1))
            wdg_cnt_q <= 32'h0000_0000; // RQ9
         else
            wdg_cnt_q <= wdg_cnt_q + 32'h0000_0001;
      end
   end

   // ==========
   // port detection and baud measurement
   // free running system tick; wrap is harmless, only differences are used
   always_ff @(posedge clk)
   begin
      if (reset)
         tick_q <= '0;
      else
         tick_q <= tick_q + 1'b1; // RQ5
   end

   // only receive lines are watched; clock and flow pins are not ports here
   assign line = sel_port_q ? port_two_receive : port_one_receive; // RQ14
   assign prev_line = sel_port_q ? prev_two_q : prev_one_q;
   assign fall = prev_line && !line;
   assign rise = !prev_line && line;
   assign fall_one = prev_one_q && !port_one_receive;
   assign fall_two = prev_two_q && !port_two_receive;
   assign elapsed = tick_q - stamp_q;
   assign high_min = WW'(low1_q) * WW'(sbps_pkg::SYNC_HIGH_MIN_BITS);
   assign high_max = WW'(low1_q) * WW'(sbps_pkg::SYNC_HIGH_MAX_BITS);
   assign low_sum = WW'(low1_q) + WW'(elapsed);
   assign locked = (det_q == sbps_pkg::DET_RUN);

   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         prev_one_q <= 1'b1;
         prev_two_q <= 1'b1;
      end
      else
      begin
         prev_one_q <= port_one_receive;
         prev_two_q <= port_two_receive;
      end
   end

   // 0x7F on the line: low start, seven high, low bit seven, high parity and stop
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         det_q <= sbps_pkg::DET_POLL;
         sel_port_q <= 1'b0;
         stamp_q <= '0;
         low1_q <= '0;
         period_q <= '0;
      end
      else
      begin
         case (det_q)
            sbps_pkg::DET_POLL:
            begin
               // no timeout: stays here as long as nothing arrives
               if (decided_q && active_q && fall_one)
               begin
                  sel_port_q <= 1'b0; // RQ2
                  stamp_q <= tick_q;
                  det_q <= sbps_pkg::DET_LOW1;
               end
               else if (decided_q && active_q && fall_two)
               begin
                  sel_port_q <= 1'b1; // RQ2
                  stamp_q <= tick_q;
                  det_q <= sbps_pkg::DET_LOW1;
               end
            end
            sbps_pkg::DET_LOW1:
            begin
               if (rise)
               begin
                  low1_q <= elapsed; // RQ19
                  stamp_q <= tick_q;
                  det_q <= sbps_pkg::DET_HIGH;
               end
               else if (&elapsed)
                  det_q <= sbps_pkg::DET_POLL;
            end
            sbps_pkg::DET_HIGH:
            begin
               // a high run outside six to eight bit times is not the sync byte
               if (fall && (WW'(elapsed) >= high_min) && (low1_q != '0))
               begin
                  stamp_q <= tick_q;
                  det_q <= sbps_pkg::DET_LOW2; // RQ3
               end
               else if (fall || (WW'(elapsed) > high_max))
                  det_q <= sbps_pkg::DET_POLL;
            end
            sbps_pkg::DET_LOW2:
            begin
               if (rise)
               begin
                  period_q <= low_sum[PERIOD_W:1]; // RQ19
                  det_q <= sbps_pkg::DET_RUN; // RQ4
               end
               else if (&elapsed)
                  det_q <= sbps_pkg::DET_POLL;
            end
            sbps_pkg::DET_RUN:
            begin
               // other port is never looked at again until reset
               if (wr_go)
               begin
                  period_q <= '0; // RQ10
                  det_q <= sbps_pkg::DET_DONE; // RQ20
               end
            end
            default:
               det_q <= sbps_pkg::DET_DONE;
         endcase
      end
   end

   // ==========
   // receiver on the locked port
   assign rx_next = {line, rx_sh_q[9:1]};

   always_ff @(posedge clk)
   begin
      if (reset || !locked)
      begin
         rx_q <= sbps_pkg::RX_IDLE;
         rx_cnt_q <= '0;
         rx_n_q <= 4'h0;
         rx_sh_q <= 10'h000;
         rx_done_q <= 1'b0;
         rx_perr_q <= 1'b0;
         rx_ferr_q <= 1'b0;
      end
      else
      begin
         rx_done_q <= 1'b0;
         case (rx_q)
            sbps_pkg::RX_IDLE:
            begin
               if (fall)
               begin
                  rx_cnt_q <= period_q >> 1;
                  rx_q <= sbps_pkg::RX_START;
               end
            end
            sbps_pkg::RX_START:
            begin
               if (rx_cnt_q != '0)
                  rx_cnt_q <= rx_cnt_q - 1'b1;
               else if (!line)
               begin
                  rx_cnt_q <= period_q - 1'b1; // reload one short: a bit spans the measured period
                  rx_n_q <= 4'h0;
                  rx_q <= sbps_pkg::RX_BITS;
               end
               else
                  rx_q <= sbps_pkg::RX_IDLE; // glitch, not a start bit
            end
            sbps_pkg::RX_BITS:
            begin
               if (rx_cnt_q != '0)
                  rx_cnt_q <= rx_cnt_q - 1'b1;
               else
               begin
                  rx_sh_q <= rx_next;
                  rx_cnt_q <= period_q - 1'b1; // RQ5
                  rx_n_q <= rx_n_q + 4'h1;
                  if (rx_n_q == sbps_pkg::RX_SAMPLES - 4'h1)
                  begin
                     rx_done_q <= 1'b1;
                     rx_perr_q <= ^rx_next[8:0]; // RQ6
                     rx_ferr_q <= !rx_next[9]; // RQ6
                     rx_q <= sbps_pkg::RX_IDLE;
                  end
               end
            end
            default:
               rx_q <= sbps_pkg::RX_IDLE;
         endcase
      end
   end

   // sticky flags: a new byte in the clearing cycle wins over the read
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         rx_valid_q <= 1'b0;
         perr_q <= 1'b0;
         ferr_q <= 1'b0;
         rx_data_q <= 8'h00;
      end
      else if (rx_done_q)
      begin
         rx_valid_q <= 1'b1;
         perr_q <= rx_perr_q;
         ferr_q <= rx_ferr_q;
         rx_data_q <= rx_sh_q[7:0];
      end
      else if (rd_rx)
      begin
         rx_valid_q <= 1'b0;
         perr_q <= 1'b0;
         ferr_q <= 1'b0;
      end
   end

   // ==========
   // transmitter on the locked port
   // write while busy or unlocked is dropped; software polls the busy bit
   always_ff @(posedge clk)
   begin
      if (reset || !locked)
      begin
         tx_busy_q <= 1'b0;
         tx_sh_q <= 11'h7FF;
         tx_cnt_q <= '0;
         tx_n_q <= 4'h0;
      end
      else if (!tx_busy_q)
      begin
         if (wr_tx)
         begin
            tx_sh_q <= {1'b1, ^avs_writedata[7:0], avs_writedata[7:0], 1'b0}; // RQ6
            tx_cnt_q <= period_q - 1'b1; // RQ5
            tx_n_q <= 4'h0;
            tx_busy_q <= 1'b1;
         end
      end
      else if (tx_cnt_q != '0)
         tx_cnt_q <= tx_cnt_q - 1'b1;
      else
      begin
         tx_sh_q <= {1'b1, tx_sh_q[10:1]};
         tx_cnt_q <= period_q - 1'b1;
         tx_n_q <= tx_n_q + 4'h1;
         if (tx_n_q == sbps_pkg::TX_FRAME_BITS - 4'h1)
            tx_busy_q <= 1'b0;
      end
   end

   // the port not chosen idles high and never drives data
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         tx1_q <= 1'b1;
         tx2_q <= 1'b1;
      end
      else
      begin
         tx1_q <= (locked && !sel_port_q) ? tx_sh_q[0] : 1'b1; // RQ4
         tx2_q <= (locked && sel_port_q) ? tx_sh_q[0] : 1'b1; // RQ4
      end
   end

   // ==========
   // Avalon slave: one wait cycle, then answer
   assign acc = (avs_read || avs_write) && !wait_q;
   assign wr_go = acc && avs_write && (avs_address == sbps_pkg::REG_CONTROL)
                  && avs_writedata[sbps_pkg::CTRL_GO_BIT];
   assign wr_tx = acc && avs_write && (avs_address == sbps_pkg::REG_TX_DATA);
   assign rd_rx = acc && avs_read && (avs_address == sbps_pkg::REG_RX_DATA);

   always_ff @(posedge clk)
   begin
      if (reset)
         wait_q <= 1'b1;
      else
         wait_q <= !((avs_read || avs_write) && wait_q);
   end

   // read data settles together with waitrequest going low
   always_ff @(posedge clk)
   begin
      if (reset)
         rdata_q <= 32'h0000_0000;
      else if (avs_read && wait_q)
      begin
         rdata_q <= 32'h0000_0000;
         if (avs_address == sbps_pkg::REG_STATUS)
         begin
            rdata_q[sbps_pkg::ST_TARGET_LSB +: 2] <= target_q;
            rdata_q[sbps_pkg::ST_ACTIVE] <= active_q;
            rdata_q[sbps_pkg::ST_LOCKED] <= locked;
            rdata_q[sbps_pkg::ST_PORT] <= sel_port_q;
            rdata_q[sbps_pkg::ST_RX_VALID] <= rx_valid_q;
            rdata_q[sbps_pkg::ST_PARITY_ERR] <= perr_q;
            rdata_q[sbps_pkg::ST_FRAME_ERR] <= ferr_q;
            rdata_q[sbps_pkg::ST_TX_BUSY] <= tx_busy_q;
         end
         else if (avs_address == sbps_pkg::REG_BIT_PERIOD)
            rdata_q[PERIOD_W-1:0] <= period_q;
         else if (avs_address == sbps_pkg::REG_RX_DATA)
            rdata_q[7:0] <= rx_data_q;
      end
   end

   // ==========
   // outputs
   assign avs_readdata = rdata_q;
   assign avs_waitrequest = wait_q;
   assign port_one_transmit = tx1_q;
   assign port_two_transmit = tx2_q;
   assign boot_target = target_q;
   assign loader_active = active_q;
   assign loader_ram_reserved = ram_res_q;
   assign app_jump = jump_q;
   assign peripheral_restore = restore_q;
   assign watchdog_prescaler_max = wdg_max_q;
   assign watchdog_refresh = wdg_ref_q;

endmodule : sbps_top

// [bench/sbps_properties.sv]
`timescale 1ns/1ps

// ==========
// port checker for the boot port selector
module sbps_properties #(
   parameter int unsigned WDG_REFRESH_CYCLES = 16
)(
   input wire logic clk,
   input wire logic reset,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic avs_waitrequest,
   input wire logic port_one_transmit,
   input wire logic port_two_transmit,
   input wire logic [1:0] boot_target,
   input wire logic loader_active,
   input wire logic loader_ram_reserved,
   input wire logic app_jump,
   input wire logic peripheral_restore,
   input wire logic watchdog_prescaler_max,
   input wire logic watchdog_refresh
);
   logic [31:0] gap_q;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (reset);

   // idle cycles since the last refresh; a counter since the gap is too long to unroll
   always_ff @(posedge clk)
   begin
      if (reset || !watchdog_prescaler_max || watchdog_refresh)
         gap_q <= 32'h0;
      else
         gap_q <= gap_q + 32'h1;
   end

   // ==========
   // sequences and properties
   sequence s_req_taken;
      (avs_read || avs_write) && avs_waitrequest;
   endsequence
   sequence s_boot_flash;
      $fell(reset) ##1 !boot_target[1];
   endsequence
   property p_wait_low;
      s_req_taken |=> !avs_waitrequest;
   endproperty
   property p_wait_one;
      !avs_waitrequest |=> avs_waitrequest;
   endproperty
   property p_flash_jump;
      s_boot_flash |-> app_jump && !loader_active;
   endproperty
   property p_active_target;
      loader_active |-> boot_target == 2'h3;
   endproperty
   property p_ram;
      loader_ram_reserved == loader_active;
   endproperty
   property p_wdg_max;
      loader_active [*2] |-> watchdog_prescaler_max;
   endproperty
   property p_wdg_gap;
      watchdog_prescaler_max |-> gap_q <= WDG_REFRESH_CYCLES;
   endproperty
   property p_wdg_pulse;
      watchdog_refresh |=> (!watchdog_refresh) [*8];
   endproperty
   property p_restore;
      peripheral_restore |-> app_jump ##1 !loader_active;
   endproperty
   property p_one_port;
      port_one_transmit || port_two_transmit;
   endproperty

   a_wait_low: assert property (p_wait_low)
      else $error("request left waiting");
   a_wait_one: assert property (p_wait_one)
      else $error("waitrequest low too long");
   a_flash_jump: assert property (p_flash_jump)
      else $error("flash boot without jump");
   a_active_target: assert property (p_active_target)
      else $error("loader running with flash target");
   a_ram: assert property (p_ram)
      else $error("ram reservation differs from session");
   a_wdg_max: assert property (p_wdg_max)
      else $error("prescaler not at maximum");
   a_wdg_gap: assert property (p_wdg_gap)
      else $error("watchdog refresh late");
   a_wdg_pulse: assert property (p_wdg_pulse)
      else $error("watchdog refresh too close");
   a_restore: assert property (p_restore)
      else $error("restore without jump or session end");
   a_one_port: assert property (p_one_port)
      else $error("both ports transmit");
endmodule : sbps_properties

bind sbps_top sbps_properties #(.WDG_REFRESH_CYCLES(WDG_REFRESH_CYCLES)) i_props (
   .clk(clk), .reset(reset), .avs_read(avs_read), .avs_write(avs_write),
   .avs_waitrequest(avs_waitrequest), .port_one_transmit(port_one_transmit),
   .port_two_transmit(port_two_transmit), .boot_target(boot_target), .loader_active(loader_active),
   .loader_ram_reserved(loader_ram_reserved), .app_jump(app_jump), .peripheral_restore(peripheral_restore),
   .watchdog_prescaler_max(watchdog_prescaler_max), .watchdog_refresh(watchdog_refresh)
);

// [bench/sbps_host_model.sv]
`timescale 1ns/1ps

// ==========
// host side of one serial port
module sbps_host_model #(
   parameter int BIT_CYCLES = 32
)(
   input wire logic clk,
   input wire logic send,
   input wire logic [7:0] tx_byte,
   input wire logic bad_parity,
   output logic line
);
   logic [10:0] frame_q;

   // idle high, so an unused port never floats
   initial line = 1'b1;

   // start, data lsb first, even parity (broken on command), stop
   always @(posedge clk)
   begin
      if (send)
      begin
         frame_q = {1'b1, (^tx_byte) ^ bad_parity, tx_byte, 1'b0};
         for (int i = 0; i < 11; i++)
         begin
            line <= frame_q[i];
            repeat (BIT_CYCLES) @(posedge clk);
         end
      end
   end
endmodule : sbps_host_model

// [bench/test_serial_boot_port_select.sv]
`timescale 1ns/1ps

// ==========
// bench for the serial boot port selector
module test_serial_boot_port_select;
   localparam int BIT_CYCLES = 32;
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic [7:0] avs_address = 8'h00;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic boot_select_a = 1'b1;
   logic boot_select_b = 1'b0;
   logic bank_two_boot_flag = 1'b1;
   logic [31:0] bank_one_start_word = 32'h0;
   logic [31:0] bank_two_start_word = 32'h0;
   logic line_one;
   logic line_two;
   logic tx_two;
   logic [1:0] boot_target;
   logic loader_active;
   logic app_jump;
   logic peripheral_restore;
   logic jump_seen = 1'b0;
   logic restore_seen = 1'b0;
   logic send_one = 1'b0;
   logic send_two = 1'b0;
   logic bad_par = 1'b0;
   logic [7:0] host_byte = 8'h00;
   logic [31:0] rd;
   logic [10:0] frame;
   int mismatches = 0;
   int cmp_count = 0;
   int cycles = 0;
   // boot cases: {select a, select b, flag}, bank two word, bank one word, target
   logic [2:0] straps [6] = '{3'h0, 3'h0, 3'h0, 3'h1, 3'h7, 3'h5};
   logic [31:0] w2s [6] = '{32'h2001_0000, 32'h2001_0004, 32'h0, 32'h2000_0000, 32'h0, 32'h0};
   logic [31:0] w1s [6] = '{32'h0, 32'h2000_0000, 32'h0, 32'h0, 32'h0, 32'h0};
   logic [1:0] tgts [6] = '{2'h1, 2'h0, 2'h3, 2'h0, 2'h2, 2'h3};

   sbps_top #(.PERIOD_W(16), .WDG_REFRESH_CYCLES(16), .SRAM_BYTES(32'h0001_0000)) i_dut (
      .clk(clk), .reset(reset), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .boot_select_a(boot_select_a), .boot_select_b(boot_select_b), .bank_two_boot_flag(bank_two_boot_flag),
      .bank_one_start_word(bank_one_start_word), .bank_two_start_word(bank_two_start_word),
      .port_one_receive(line_one), .port_two_receive(line_two), .port_one_transmit(),
      .port_two_transmit(tx_two), .boot_target(boot_target), .loader_active(loader_active),
      .loader_ram_reserved(), .app_jump(app_jump), .peripheral_restore(peripheral_restore),
      .watchdog_prescaler_max(), .watchdog_refresh()
   );
   sbps_host_model #(.BIT_CYCLES(BIT_CYCLES)) i_host_one (
      .clk(clk), .send(send_one), .tx_byte(host_byte), .bad_parity(bad_par), .line(line_one)
   );
   sbps_host_model #(.BIT_CYCLES(BIT_CYCLES)) i_host_two (
      .clk(clk), .send(send_two), .tx_byte(host_byte), .bad_parity(bad_par), .line(line_two)
   );

   always #2.5 clk = ~clk;

   // sticky pulse catchers; a hang ceiling so a stuck handshake still ends the run
   always @(posedge clk)
   begin
      jump_seen <= reset ? 1'b0 : (jump_seen | app_jump);
      restore_seen <= reset ? 1'b0 : (restore_seen | peripheral_restore);
      cycles <= cycles + 1;
      if (cycles == 10000)
      begin
         mismatches = mismatches + 1;
         give_verdict();
      end
   end

   // ==========
   // tasks
   task automatic give_verdict();
      $display("compares %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : give_verdict

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count = cmp_count + 1;
      if (seen !== exp)
      begin
         mismatches = mismatches + 1;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk

   // one avalon transfer, held until waitrequest is sampled low
   task automatic bus_xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] d);
      avs_address <= a;
      avs_writedata <= wd;
      avs_read <= !wr;
      avs_write <= wr;
      @(posedge clk);
      while (avs_waitrequest !== 1'b0)
         @(posedge clk);
      d = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      @(posedge clk);
   endtask : bus_xfer

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      bus_xfer(1'b0, a, 32'h0, rd);
      chk(rd & m, e);
   endtask : rd_chk

   task automatic restart(input logic [2:0] s, input logic [31:0] w2, input logic [31:0] w1);
      {boot_select_a, boot_select_b, bank_two_boot_flag} <= s;
      bank_two_start_word <= w2;
      bank_one_start_word <= w1;
      reset <= 1'b1;
      repeat (5) @(posedge clk);
      reset <= 1'b0;
      repeat (4) @(posedge clk);
   endtask : restart

   // one whole frame from a host; frame length is fixed by the bit period we set
   task automatic send(input logic two, input logic [7:0] b, input logic bp);
      host_byte <= b;
      bad_par <= bp;
      send_one <= !two;
      send_two <= two;
      @(posedge clk);
      send_one <= 1'b0;
      send_two <= 1'b0;
      repeat (12 * BIT_CYCLES) @(posedge clk);
   endtask : send

   // device bits last exactly the measured period; sample mid-bit
   task automatic get_tx(output logic [10:0] f);
      while (tx_two !== 1'b0)
         @(posedge clk);
      repeat (BIT_CYCLES / 2) @(posedge clk);
      for (int i = 0; i < 11; i++)
      begin
         f[i] = tx_two;
         repeat (BIT_CYCLES) @(posedge clk);
      end
   endtask : get_tx

   // ==========
   // main sequence
   initial
   begin
      for (int i = 0; i < 6; i++)
      begin
         restart(straps[i], w2s[i], w1s[i]);
         chk({30'h0, boot_target}, {30'h0, tgts[i]});
         chk({31'h0, loader_active}, {31'h0, tgts[i] == 2'h3});
         chk({31'h0, jump_seen}, {31'h0, !tgts[i][1]});
      end
      rd_chk(8'h14, 32'hFFFF_FFFF, 32'h0);
      rd_chk(8'h00, 32'h0000_0F1F, 32'h0000_0007);
      send(1'b1, 8'h7F, 1'b0);
      rd_chk(8'h00, 32'h0000_0F1F, 32'h0000_001F);
      rd_chk(8'h04, 32'h0000_FFFF, 32'(BIT_CYCLES));
      send(1'b0, 8'h7F, 1'b0);
      rd_chk(8'h00, 32'h0000_0F1F, 32'h0000_001F);
      send(1'b1, 8'hA5, 1'b0);
      rd_chk(8'h08, 32'h0000_00FF, 32'h0000_00A5);
      rd_chk(8'h00, 32'h0000_0F1F, 32'h0000_001F);
      send(1'b1, 8'h3C, 1'b1);
      rd_chk(8'h00, 32'h0000_0F1F, 32'h0000_031F);
      rd_chk(8'h08, 32'h0000_00FF, 32'h0000_003C);
      bus_xfer(1'b1, 8'h0C, 32'h0000_00C3, rd);
      get_tx(frame);
      chk({21'h0, frame}, {21'h0, 1'b1, ^8'hC3, 8'hC3, 1'b0});
      bus_xfer(1'b1, 8'h10, 32'h0000_0001, rd);
      repeat (2) @(posedge clk);
      chk({31'h0, restore_seen}, 32'h0000_0001);
      rd_chk(8'h00, 32'h0000_000C, 32'h0);
      give_verdict();
   end
endmodule : test_serial_boot_port_select
